// >>> core/srpc_top.v
// Refresh, clock suspend, power-down and data mask control of the memory device.
`timescale 1ns/1ps
`default_nettype none
`include "srpc_consts.vh"

// Functional notes
// (R1) Periodic refresh: RAS, CAS low, WE high, CKE high
// (R2) Internal row counter advances on each refresh
// (R3) Controller refreshes 4096 times per window
// (R4) Controller refreshes only idle, not powered down
// (R5) Controller sends NOPs until row cycle ends
// (R6) Controller spaces refreshes by precharge time
// (R7) Retention entry: refresh encoding with CKE low
// (R8) Retention ignores all but CKE, self-timed
// (R9) Controller restarts clock, then raises CKE
// (R10) Controller waits exit delay after retention exit
// (R11) Burst refresh recommended around retention mode
// (R12) CKE low in burst masks clock next cycle
// (R13) CKE low while idle enters power-down
// (R14) Controller limits suspend and power-down duration
// (R15) CKE high restarts clock from next cycle
// (R16) Controller observes power-down exit delay
// (R17) Mask high blocks writing that word
// (R18) Mask high disables read output buffers
// (R19) NOP command performs no action
// (R20) Chip select high ignores strobes, addresses
// (R21) Write mask same cycle, read disable two later
module srpc_top #(
  parameter ROW_BITS = `SRPC_ROW_BITS,
  parameter RETENTION_CYCLES = `SRPC_RETENTION_CYCLES,
  parameter ROW_CYCLE_CYCLES = `SRPC_ROW_CYCLE_CYCLES
) (
  // System
  input wire I_CLK,
  input wire I_RESET,
  // Memory pins from the controller
  input wire i_LINK_CLK,
  input wire i_CS_N,
  input wire i_RAS_N,
  input wire i_CAS_N,
  input wire i_WE_N,
  input wire i_CKE,
  input wire i_DQM,
  // Status from the rest of the device
  input wire i_BANKS_IDLE,
  input wire i_BURST_ACTIVE,
  input wire i_WRITE_ACTIVE,
  input wire i_READ_ACTIVE,
  // Internal clock control
  output reg o_INT_TICK,
  output reg o_CLOCK_SUSPEND,
  output reg o_IDLE_LOW_POWER,
  output reg o_RETENTION_MODE,
  output reg o_INPUT_BUF_EN,
  // Refresh
  output reg o_REFRESH_STROBE,
  output reg [ROW_BITS-1:0] o_REFRESH_ROW,
  output reg o_REFRESH_BUSY,
  // Data mask
  output reg o_WORD_WRITE_EN,
  output reg o_DQ_OE
);

  // ---------------------------------------------------------------
  // Pin synchronisation and link clock edges
  // ---------------------------------------------------------------
  wire [`SRPC_PIN_COUNT-1:0] pins_raw;
  wire [`SRPC_PIN_COUNT-1:0] pins;
  reg link_clk_d;
  reg cap_cs_n;
  reg cap_ras_n;
  reg cap_cas_n;
  reg cap_we_n;
  reg cap_cke;
  reg cap_dqm;

  assign pins_raw = {i_DQM, i_CKE, i_WE_N, i_CAS_N, i_RAS_N, i_CS_N, i_LINK_CLK};

  srpc_sync #(
    .WIDTH(`SRPC_PIN_COUNT)
  ) u_pin_sync (
    .i_clk(I_CLK),
    .i_reset(I_RESET),
    .i_async(pins_raw),
    .o_sync(pins)
  );

  wire link_rise = pins[`SRPC_PIN_CLK] & ~link_clk_d;
  wire link_fall = ~pins[`SRPC_PIN_CLK] & link_clk_d;

  // Pins are captured mid-period, on the falling edge, where they are stable.
  // The value taken there is the one the device registers at the next rising edge.
  always @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      link_clk_d <= 1'b0;
      cap_cs_n <= 1'b1;
      cap_ras_n <= 1'b1;
      cap_cas_n <= 1'b1;
      cap_we_n <= 1'b1;
      cap_cke <= 1'b0;
      cap_dqm <= 1'b1;
    end else begin
      link_clk_d <= pins[`SRPC_PIN_CLK];
      if (link_fall) begin
        cap_cs_n <= pins[`SRPC_PIN_CS_N];
        cap_ras_n <= pins[`SRPC_PIN_RAS_N];
        cap_cas_n <= pins[`SRPC_PIN_CAS_N];
        cap_we_n <= pins[`SRPC_PIN_WE_N];
        cap_cke <= pins[`SRPC_PIN_CKE];
        cap_dqm <= pins[`SRPC_PIN_DQM];
      end
    end
  end

  // ---------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------
  // Deselect blocks every command; NOP matches no encoding and so does nothing.
  wire selected = ~cap_cs_n; // R20 R19
  wire refresh_enc = selected & ~cap_ras_n & ~cap_cas_n & cap_we_n; // R1 R7

  // ---------------------------------------------------------------
  // Power state machine
  // ---------------------------------------------------------------
  reg [1:0] state;
  reg [1:0] next_state;
  reg cke_prev;
  reg next_tick;
  reg next_periodic;
  reg next_enter_retention;

  always @* begin
    next_state = state;
    next_tick = 1'b0;
    next_periodic = 1'b0;
    next_enter_retention = 1'b0;
    if (link_rise) begin
      case (state)
        `SRPC_ST_ACTIVE: begin
          if (cke_prev) begin
            next_tick = 1'b1;
            if (refresh_enc && cap_cke) begin
              next_periodic = 1'b1; // R1
            end else if (refresh_enc && i_BANKS_IDLE) begin
              next_state = `SRPC_ST_RETENTION; // R7
              next_enter_retention = 1'b1;
            end else if (!cap_cke && i_BANKS_IDLE && !i_BURST_ACTIVE) begin
              next_state = `SRPC_ST_IDLE_LOW_POWER_STATE; // R13
            end else if (!cap_cke) begin
              next_state = `SRPC_ST_SUSPEND; // R12
            end
          end else if (cap_cke) begin
            next_state = `SRPC_ST_ACTIVE;
          end
        end
        `SRPC_ST_SUSPEND: begin
          if (cap_cke) begin
            next_state = `SRPC_ST_ACTIVE; // R15
          end
        end
        `SRPC_ST_IDLE_LOW_POWER_STATE: begin
          if (cap_cke) begin
            next_state = `SRPC_ST_ACTIVE; // R15
          end
        end
        default: begin
          // Only CKE is looked at while retention refresh runs.
          if (cap_cke) begin
            next_state = `SRPC_ST_ACTIVE; // R8
          end
        end
      endcase
    end
  end

  // The tick is only issued when CKE was high at the previous edge, so a low CKE
  // masks the internal clock starting with the edge after it was sampled.
  always @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      state <= `SRPC_ST_ACTIVE;
      cke_prev <= 1'b0;
      o_INT_TICK <= 1'b0;
      o_CLOCK_SUSPEND <= 1'b0;
      o_IDLE_LOW_POWER <= 1'b0;
      o_RETENTION_MODE <= 1'b0;
      o_INPUT_BUF_EN <= 1'b1;
    end else begin
      state <= next_state;
      if (link_rise) begin
        cke_prev <= cap_cke; // R12 R15
      end
      o_INT_TICK <= next_tick;
      o_CLOCK_SUSPEND <= (next_state == `SRPC_ST_SUSPEND);
      o_IDLE_LOW_POWER <= (next_state == `SRPC_ST_IDLE_LOW_POWER_STATE);
      o_RETENTION_MODE <= (next_state == `SRPC_ST_RETENTION);
      o_INPUT_BUF_EN <= (next_state != `SRPC_ST_IDLE_LOW_POWER_STATE) &&
                        (next_state != `SRPC_ST_RETENTION); // R13
    end
  end

  // ---------------------------------------------------------------
  // Refresh row counter and self-timed retention refresh
  // ---------------------------------------------------------------
  localparam TIMER_BITS = 16;
  localparam BUSY_BITS = 8;
  // The counters are cut to their own widths here, so a larger count is truncated.
  localparam [31:0] RET_LAST_FULL = RETENTION_CYCLES - 1;
  localparam [31:0] BUSY_LOAD_FULL = ROW_CYCLE_CYCLES;
  localparam [TIMER_BITS-1:0] RET_LAST = RET_LAST_FULL[TIMER_BITS-1:0];
  localparam [BUSY_BITS-1:0] BUSY_LOAD = BUSY_LOAD_FULL[BUSY_BITS-1:0];

  reg [TIMER_BITS-1:0] ret_timer;
  reg [BUSY_BITS-1:0] busy_count;
  wire timed_refresh = (state == `SRPC_ST_RETENTION) && (ret_timer == RET_LAST);
  wire refresh_now = next_periodic | timed_refresh;

  // The retention timer keeps running on the system clock, since the link
  // clock may be stopped for the whole time retention refresh is active.
  always @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      ret_timer <= {TIMER_BITS{1'b0}};
      busy_count <= {BUSY_BITS{1'b0}};
      o_REFRESH_STROBE <= 1'b0;
      o_REFRESH_ROW <= {ROW_BITS{1'b0}};
      o_REFRESH_BUSY <= 1'b0;
    end else begin
      if (state != `SRPC_ST_RETENTION || next_enter_retention || timed_refresh) begin
        ret_timer <= {TIMER_BITS{1'b0}};
      end else begin
        ret_timer <= ret_timer + 1'b1; // R8
      end
      o_REFRESH_STROBE <= refresh_now;
      if (refresh_now) begin
        o_REFRESH_ROW <= o_REFRESH_ROW + 1'b1; // R2
        busy_count <= BUSY_LOAD;
        o_REFRESH_BUSY <= 1'b1;
      end else if (busy_count != {BUSY_BITS{1'b0}}) begin
        busy_count <= busy_count - 1'b1;
        o_REFRESH_BUSY <= (busy_count != {{(BUSY_BITS-1){1'b0}}, 1'b1});
      end else begin
        o_REFRESH_BUSY <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Data mask: write word enable and read output disable
  // ---------------------------------------------------------------
  // Three stages, so a mask reaches the output buffers only after the second
  // tick that follows the one at which it was sampled.
  reg [2:0] oe_pipe;

  always @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      oe_pipe <= 3'h0;
      o_WORD_WRITE_EN <= 1'b0;
      o_DQ_OE <= 1'b0;
    end else begin
      o_WORD_WRITE_EN <= next_tick && i_WRITE_ACTIVE && !cap_dqm; // R17 R21
      if (next_tick) begin
        oe_pipe <= {oe_pipe[1:0], !cap_dqm}; // R18 R21
      end
      o_DQ_OE <= i_READ_ACTIVE && oe_pipe[2] &&
                 (state == `SRPC_ST_ACTIVE || state == `SRPC_ST_SUSPEND); // R18
    end
  end

endmodule

`default_nettype wire

// >>> shared/srpc_consts.vh
// Shared constants for the refresh and power control block.
`ifndef SRPC_CONSTS_VH
`define SRPC_CONSTS_VH

// ---------------------------------------------------------------
// Clock and timing
// ---------------------------------------------------------------
`define SRPC_CLK_PERIOD_NS 4
`define SRPC_REFRESH_WINDOW_MS 64
`define SRPC_REFRESH_COUNT 4096
`define SRPC_ROW_BITS 12
`define SRPC_ROW_CYCLE_NS 60
`define SRPC_ROW_CYCLE_CYCLES ((`SRPC_ROW_CYCLE_NS + `SRPC_CLK_PERIOD_NS - 1) / `SRPC_CLK_PERIOD_NS)
`define SRPC_RETENTION_CYCLES ((`SRPC_REFRESH_WINDOW_MS * 1000000 / `SRPC_REFRESH_COUNT) / `SRPC_CLK_PERIOD_NS)

// ---------------------------------------------------------------
// Pin positions inside the synchronised pin vector
// ---------------------------------------------------------------
`define SRPC_PIN_COUNT 7
`define SRPC_PIN_CLK 0
`define SRPC_PIN_CS_N 1
`define SRPC_PIN_RAS_N 2
`define SRPC_PIN_CAS_N 3
`define SRPC_PIN_WE_N 4
`define SRPC_PIN_CKE 5
`define SRPC_PIN_DQM 6

// ---------------------------------------------------------------
// Power states
// ---------------------------------------------------------------
`define SRPC_ST_ACTIVE 2'h0
`define SRPC_ST_SUSPEND 2'h1
`define SRPC_ST_IDLE_LOW_POWER_STATE 2'h2
`define SRPC_ST_RETENTION 2'h3

`endif

// >>> core/srpc_sync.v
// Two-stage synchroniser for a vector of pins.
`timescale 1ns/1ps
`default_nettype none

module srpc_sync #(
  parameter WIDTH = 1
) (
  input wire i_clk,
  input wire i_reset,
  input wire [WIDTH-1:0] i_async,
  output reg [WIDTH-1:0] o_sync
);

  reg [WIDTH-1:0] stage1;

  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      stage1 <= {WIDTH{1'b0}};
      o_sync <= {WIDTH{1'b0}};
    end else begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end

endmodule

`default_nettype wire

// >>> verif/srpc_ctl_model.sv
// Memory controller model: link clock and command pins.
`timescale 1ns/1ps
`default_nettype none
module srpc_ctl_model (
  // Bench side
  input wire logic i_clk,
  input wire logic i_run,
  // Memory pins, o_pins is {cs_n, ras_n, cas_n, we_n, cke, dqm}
  output logic o_link_clk,
  output logic [5:0] o_pins
);
  // The clock parks low while stopped, and is restarted before the gate rises.
  initial begin
    o_link_clk = 1'b0;
    #7.3;
    forever #40 o_link_clk = i_run ? ~o_link_clk : 1'b0;
  end
  initial o_pins = 6'h1E;
  // Pins change just after a link rise and hold for a whole link cycle.
  task automatic cmd(input logic [5:0] c);
    @(posedge o_link_clk);
    @(negedge i_clk);
    o_pins <= c;
  endtask
endmodule
`default_nettype wire

// >>> verif/srpc_chk.sv
// Port checker for the refresh and power control block.
`timescale 1ns/1ps
`default_nettype none
module srpc_chk #(
  parameter ROW_BITS = 12
) (
  // System
  input wire logic I_CLK,
  input wire logic I_RESET,
  input wire logic i_READ_ACTIVE,
  // Outputs watched
  input wire logic o_INT_TICK,
  input wire logic o_CLOCK_SUSPEND,
  input wire logic o_IDLE_LOW_POWER,
  input wire logic o_RETENTION_MODE,
  input wire logic o_INPUT_BUF_EN,
  input wire logic o_REFRESH_STROBE,
  input wire logic [ROW_BITS-1:0] o_REFRESH_ROW,
  input wire logic o_REFRESH_BUSY,
  input wire logic o_WORD_WRITE_EN,
  input wire logic o_DQ_OE
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_RESET);
  a_row_advance: assert property (
    o_REFRESH_STROBE |-> o_REFRESH_ROW == $past(o_REFRESH_ROW) + 1'b1) else $error("row step");
  a_row_hold: assert property (
    !o_REFRESH_STROBE |-> $stable(o_REFRESH_ROW)) else $error("row moved");
  a_busy_hold: assert property (
    o_REFRESH_STROBE |-> o_REFRESH_BUSY [*8]) else $error("busy short");
  a_busy_len: assert property (
    $fell(o_REFRESH_BUSY) |-> $past(o_REFRESH_STROBE, 15)) else $error("busy length");
  a_pd_quiet: assert property (
    o_IDLE_LOW_POWER && $past(o_IDLE_LOW_POWER) |-> !o_INT_TICK && !o_INPUT_BUF_EN && !o_DQ_OE)
    else $error("power-down active");
  a_susp_frozen: assert property (
    o_CLOCK_SUSPEND && $past(o_CLOCK_SUSPEND) |-> !o_INT_TICK && !o_REFRESH_STROBE)
    else $error("suspend ticked");
  a_ret_ignore: assert property (
    o_RETENTION_MODE && $past(o_RETENTION_MODE) |-> !o_INT_TICK && !o_INPUT_BUF_EN)
    else $error("retention ticked");
  a_exit_late: assert property (
    $fell(o_IDLE_LOW_POWER) || $fell(o_CLOCK_SUSPEND) |-> !o_INT_TICK) else $error("early tick");
  a_one_state: assert property (
    $onehot0({o_CLOCK_SUSPEND, o_IDLE_LOW_POWER, o_RETENTION_MODE})) else $error("states");
  a_word_tick: assert property (
    o_WORD_WRITE_EN |-> o_INT_TICK) else $error("word without tick");
  a_oe_read: assert property (
    o_DQ_OE |-> $past(i_READ_ACTIVE)) else $error("oe outside read");
  c_ret_refresh: cover property (o_RETENTION_MODE && o_REFRESH_STROBE);
  c_idle_low_power_state: cover property ($rose(o_IDLE_LOW_POWER));
  c_oe_off: cover property ($fell(o_DQ_OE));
endmodule
bind srpc_top srpc_chk #(.ROW_BITS(ROW_BITS)) chk_u (.I_CLK, .I_RESET, .i_READ_ACTIVE,
  .o_INT_TICK, .o_CLOCK_SUSPEND, .o_IDLE_LOW_POWER, .o_RETENTION_MODE, .o_INPUT_BUF_EN,
  .o_REFRESH_STROBE, .o_REFRESH_ROW, .o_REFRESH_BUSY, .o_WORD_WRITE_EN, .o_DQ_OE);
`default_nettype wire

// >>> verif/tb_sdram_refresh_power_control.sv
// Self-checking bench for the refresh and power control block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb_sdram_refresh_power_control;
  localparam logic [5:0] NOP = 6'h1E;
  localparam logic [5:0] NOP_M = 6'h1F;
  localparam logic [5:0] REF = 6'h06;
  localparam logic [5:0] DESEL = 6'h26;
  localparam logic [5:0] ENTRY = 6'h04;
  localparam logic [5:0] HOLD = 6'h1C;
  logic clk, rst, run, lclk, idle, burst, wr, rd;
  logic tick, susp, lp, ret, buf_en, strb, busy, wen, oe;
  logic [5:0] pins;
  logic [11:0] row;
  int n_fail, checks_done, n_tick, n_strb, n_wen, b;
  srpc_ctl_model mdl_u (.i_clk(clk), .i_run(run), .o_link_clk(lclk), .o_pins(pins));
  srpc_top #(.RETENTION_CYCLES(20)) dut_u (.I_CLK(clk), .I_RESET(rst), .i_LINK_CLK(lclk),
    .i_CS_N(pins[5]), .i_RAS_N(pins[4]), .i_CAS_N(pins[3]), .i_WE_N(pins[2]),
    .i_CKE(pins[1]), .i_DQM(pins[0]), .i_BANKS_IDLE(idle), .i_BURST_ACTIVE(burst),
    .i_WRITE_ACTIVE(wr), .i_READ_ACTIVE(rd), .o_INT_TICK(tick), .o_CLOCK_SUSPEND(susp),
    .o_IDLE_LOW_POWER(lp), .o_RETENTION_MODE(ret), .o_INPUT_BUF_EN(buf_en),
    .o_REFRESH_STROBE(strb), .o_REFRESH_ROW(row), .o_REFRESH_BUSY(busy),
    .o_WORD_WRITE_EN(wen), .o_DQ_OE(oe));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    n_tick <= n_tick + (tick === 1'b1);
    n_strb <= n_strb + (strb === 1'b1);
    n_wen <= n_wen + (wen === 1'b1);
  end
  // A command takes effect during the following call, once its link rise has been decoded.
  task automatic go(input logic [5:0] c);
    mdl_u.cmd(c);
    repeat (8) @(negedge clk);
  endtask
  task automatic t_refresh;
    go(NOP);
    b = n_strb;
    go(REF);
    go(NOP);
    `CHK(n_strb - b, 1)
    `CHK(row, 12'h001)
    `CHK(busy, 1'b1)
    go(REF);
    `CHK(busy, 1'b0)
    go(NOP);
    `CHK(row, 12'h002)
    b = n_strb;
    go(DESEL);
    go(NOP);
    `CHK(n_strb - b, 0)
    $display("refresh and deselect done");
  endtask
  task automatic t_mask;
    wr = 1'b1;
    go(NOP_M);
    b = n_wen;
    go(NOP_M);
    go(NOP);
    go(NOP);
    `CHK(n_wen - b, 1)
    wr = 1'b0;
    rd = 1'b1;
    repeat (3) go(NOP);
    `CHK(oe, 1'b1)
    repeat (3) go(NOP_M);
    `CHK(oe, 1'b1)
    go(NOP_M);
    `CHK(oe, 1'b0)
    rd = 1'b0;
    $display("mask done");
  endtask
  task automatic t_power;
    go(HOLD);
    go(HOLD);
    b = n_tick;
    go(HOLD);
    `CHK(lp, 1'b1)
    `CHK(buf_en, 1'b0)
    `CHK(n_tick - b, 0)
    go(NOP);
    go(NOP);
    `CHK(lp, 1'b0)
    `CHK(buf_en, 1'b1)
    b = n_tick;
    go(NOP);
    `CHK(n_tick - b, 1)
    burst = 1'b1;
    idle = 1'b0;
    go(HOLD);
    go(HOLD);
    `CHK({susp, lp}, 2'h2)
    go(NOP);
    go(NOP);
    `CHK(susp, 1'b0)
    burst = 1'b0;
    idle = 1'b1;
    $display("power-down and suspend done");
  endtask
  task automatic t_retention;
    repeat (4) go(REF);
    go(NOP);
    `CHK(row, 12'h006)
    b = n_strb;
    go(ENTRY);
    go(HOLD);
    `CHK(ret, 1'b1)
    `CHK(buf_en, 1'b0)
    `CHK(n_strb - b, 0)
    run = 1'b0;
    repeat (100) @(negedge clk);
    `CHK((n_strb - b >= 4) && (n_strb - b <= 6), 1'b1)
    `CHK(row, 12'h006 + 12'(n_strb - b + strb))
    run = 1'b1;
    go(NOP);
    go(NOP);
    `CHK({ret, buf_en}, 2'h1)
    $display("retention done");
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    run = 1'b1;
    idle = 1'b1;
    burst = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    t_refresh;
    t_mask;
    t_power;
    t_retention;
    wrap_up;
  end
  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    wrap_up;
  end
endmodule
`default_nettype wire
